// >>> dv/asrp_host_model.sv
// host model that selects the port and reads words in either role
`timescale 1ns/1ps
`default_nettype none
module asrp_host_model (
    input  wire logic        clk_i,
    input  wire logic        en_i,
    input  wire logic        ext_i,
    input  wire logic        slow_i,
    input  wire logic        hold_i,
    input  wire logic        rdy_n_i,
    input  wire logic        sdo_i,
    input  wire logic        sdo_oe_i,
    input  wire logic        sclk_i,
    input  wire logic        sclk_oe_i,
    output logic             cs_n_o,
    output logic             sclk_link_o,
    output logic [15:0]      word_o,
    output logic             got_t_o,
    output logic             err_o
);
    logic        sdo_w;
    logic        sclk_w;
    logic        smp_clk;
    logic [15:0] sh;
    int          cnt;
    // pull-downs: a released line reads low, never the last driven value
    assign sdo_w   = sdo_oe_i ? sdo_i : 1'b0;
    assign sclk_w  = sclk_oe_i ? sclk_i : 1'b0;
    assign smp_clk = ext_i ? sclk_link_o : sclk_w;
    initial begin
        cs_n_o = 1'b1;
        sclk_link_o = 1'b0;
        word_o = 16'h0000;
        got_t_o = 1'b0;
        err_o = 1'b0;
        sh = 16'h0000;
        cnt = 0;
    end
    always @(posedge smp_clk) if (!cs_n_o) begin
        sh = {sh[14:0], sdo_w};
        cnt = cnt + 1;
        if (cnt == 16) begin
            cnt = 0;
            word_o = sh;
            got_t_o = ~got_t_o;
        end
    end
    task automatic wait_rdy_high();
        int n;
        n = 0;
        while (rdy_n_i !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 400) err_o = 1'b1;
    endtask
    // link clock stands still outside frames; slow host leaves gaps
    always begin
        @(negedge clk_i);
        if (hold_i) cs_n_o = 1'b0;
        else if (!en_i) cs_n_o = 1'b1;
        else if (!ext_i && !slow_i) cs_n_o = 1'b0;
        else if (rdy_n_i === 1'b0) begin
            if (slow_i) repeat ($urandom_range(12, 3)) @(negedge clk_i);
            cs_n_o = 1'b0;
            if (ext_i) begin
                repeat (4) @(negedge clk_i);
                #($urandom_range(17, 1));
                for (int b = 0; b < 16; b++) begin
                    #15 sclk_link_o = 1'b1;
                    #15 sclk_link_o = 1'b0;
                    if (slow_i && b[1]) #($urandom_range(90, 20));
                end
            end
            wait_rdy_high();
            cs_n_o = 1'b1;
        end
    end
endmodule // asrp_host_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the serial readout port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        strap = 1'b0;
    logic        valid = 1'b0;
    logic        en = 1'b0;
    logic        ext = 1'b1;
    logic        slow = 1'b0;
    logic        hold = 1'b0;
    logic [15:0] data = 16'h0000;
    logic [15:0] host_word;
    logic        cs_n, sclk_link, word_ready, rdy_n, serial_data_output, sdo_oe, sclk, sclk_oe;
    logic        self_mode, got_t, err;
    int          bad_count = 0;
    int          compares = 0;
    int          dummy;
    int          acc;
    logic [15:0] exp_q[$];
    always #20 clk_i = ~clk_i;
    asrp_port dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .port_role_strap_i(strap),
        .cs_n_i(cs_n), .sclk_link_i(sclk_link), .word_valid_i(valid),
        .word_data_i(data), .word_ready_o(word_ready), .rdy_n_o(rdy_n),
        .serial_data_output_o(serial_data_output), .serial_data_output_oe_o(sdo_oe),
        .sclk_o(sclk), .sclk_oe_o(sclk_oe), .self_clocked_mode_o(self_mode));
    asrp_host_model host_u (
        .clk_i(clk_i), .en_i(en), .ext_i(ext), .slow_i(slow), .hold_i(hold), .rdy_n_i(rdy_n),
        .sdo_i(serial_data_output), .sdo_oe_i(sdo_oe), .sclk_i(sclk), .sclk_oe_i(sclk_oe),
        .cs_n_o(cs_n), .sclk_link_o(sclk_link), .word_o(host_word),
        .got_t_o(got_t), .err_o(err));
    // ------------------------------------------------------------
    // comparison, stimulus and closing tasks
    // ------------------------------------------------------------
    task automatic fail(input string what);
        bad_count++;
        $display("CHECK FAILED t=%0t %s", $time, what);
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
    endtask
    task automatic chk_num(input int got, input int exp);
        compares++;
        if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic push(input int n, output int got);
        got = 0;
        for (int i = 0; i < n; i++) begin
            valid = 1'b1;
            data = 16'($urandom);
            // ready is settled here; at the edge it would race its own update
            if (word_ready === 1'b1) begin
                exp_q.push_back(data);
                got++;
            end
            @(negedge clk_i);
        end
        valid = 1'b0;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 4000) begin
            fail("drain timed out");
            results();
        end
        repeat (20) @(negedge clk_i);
    endtask
    // ------------------------------------------------------------
    // result watchers
    // ------------------------------------------------------------
    always @(got_t) begin
        logic [15:0] e;
        int n;
        if (rst_i === 1'b0) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : ~host_word;
            chk_word(host_word, e);
            n = 0;
            while (rdy_n !== 1'b1 && n < 40) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            if (ext) chk_bit(n <= 12, 1'b1);
            else chk_num(n, 8);
        end
    end
    always @(negedge rdy_n) if (!ext && sdo_oe === 1'b1 && exp_q.size() > 0)
        chk_bit(serial_data_output, exp_q[0][15]);
    always @(negedge cs_n) begin
        int n;
        n = 0;
        if (!ext && slow) begin
            while (sclk !== 1'b1 && n < 20) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            chk_bit(n >= 9 && n <= 11, 1'b1);
        end
    end
    always @(posedge err) begin
        fail("host wait expired");
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        dummy = $urandom(32'h9ac9);
        repeat (4) @(posedge clk_i);
        @(negedge clk_i) rst_i = 1'b0;
        chk_bit(rdy_n, 1'b1);
        chk_bit(sdo_oe, 1'b0);
        chk_bit(sclk_oe, 1'b0);
        chk_bit(word_ready, 1'b1);
        $display("test reset done");
        // roles: external prompt, external slow, self prompt, self slow
        for (int m = 0; m < 4; m++) begin
            ext = (m < 2);
            slow = m[0];
            strap = ~ext;
            repeat (12) @(negedge clk_i);
            chk_bit(self_mode, ~ext);
            en = 1'b1;
            push(5, acc);
            drain();
            chk_bit(sdo_oe, m == 2);
            chk_bit(sclk_oe, m == 2);
            en = 1'b0;
            repeat (4) @(negedge clk_i);
            chk_bit(sdo_oe, 1'b0);
            chk_bit(sclk_oe, 1'b0);
            $display("test role %0d done", m);
        end
        // host holds select low without clocking: unread words give way
        ext = 1'b1;
        strap = 1'b0;
        hold = 1'b1;
        repeat (12) @(negedge clk_i);
        push(3, acc);
        repeat (30) @(negedge clk_i);
        while (exp_q.size() > 1) void'(exp_q.pop_front());
        chk_bit(rdy_n, 1'b0);
        hold = 1'b0;
        en = 1'b1;
        drain();
        en = 1'b0;
        $display("test drop done");
        // host stalls while the buffer fills, then drains it
        ext = 1'b1;
        strap = 1'b0;
        repeat (12) @(negedge clk_i);
        push(20, acc);
        // sixteen stored, one in the output register, one waiting in the port
        chk_num(acc, 18);
        chk_bit(word_ready, 1'b0);
        en = 1'b1;
        drain();
        chk_bit(word_ready, 1'b1);
        $display("test fill done");
        results();
    end
endmodule // testbench
`default_nettype wire

// >>> hdl/asrp_fifo.sv
// word buffer with registered read data, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asrp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             en_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wp_r;
    logic [PW-1:0]    rp_r;
    logic [CW-1:0]    cnt_r;
    logic             push;
    logic             pop;
    logic             take;

    assign in_ready_o = (cnt_r != FULL);
    assign push       = in_valid_i & in_ready_o;
    // the output register refills whenever it is empty or being drained
    assign take       = ~out_valid_o | out_ready_i;
    assign pop        = take & (cnt_r != '0);

    always_ff @(posedge clk_i) begin
        if (en_i && push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (en_i) begin
            if (push) begin
                wp_r <= PW'(wp_r + 1'b1);
            end
            if (pop) begin
                rp_r <= PW'(rp_r + 1'b1);
            end
            cnt_r <= CW'(cnt_r + CW'(push) - CW'(pop));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (en_i && take) begin
            out_valid_o <= pop;
            if (pop) begin
                out_data_o <= mem_r[rp_r];
            end
        end
    end
endmodule // asrp_fifo
`default_nettype wire

// >>> hdl/asrp_pkg.sv
// constants and types shared by the serial readout port
`default_nettype none
package asrp_pkg;
    // ------------------------------------------------------------
    // word and buffer shape
    // ------------------------------------------------------------
    localparam int WORD_W     = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int LCNT_W     = 5;
    localparam int CNT_W      = 4;
    // ------------------------------------------------------------
    // timing, in master clock cycles unless named otherwise
    // ------------------------------------------------------------
    localparam int MCLK_HZ           = 25_000_000;
    localparam int SSC_DIV           = 2;
    localparam int EXT_PHASE_MIN_NS  = 30;
    localparam logic [CNT_W-1:0] MSB_LEAD_CYC  = 4'h2;
    localparam logic [CNT_W-1:0] SCLK_LEAD_CYC = 4'h8;
    localparam logic [CNT_W-1:0] RDY_TAIL_CYC  = 4'h8;
    localparam logic [CNT_W-1:0] RDY_PRE_CYC   = 4'h2;
    localparam logic [CNT_W-1:0] STRAP_SETTLE  = 4'h3;
    localparam logic [LCNT_W-1:0] WORD_BITS    = 5'h10;
    // ------------------------------------------------------------
    // port sequencer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_LOAD  = 7'b0000010,
        ST_WAIT  = 7'b0000100,
        ST_LEAD  = 7'b0001000,
        ST_SHIFT = 7'b0010000,
        ST_TAIL  = 7'b0100000,
        ST_DROP  = 7'b1000000
    } asrp_state_type;
endpackage
`default_nettype wire

// >>> hdl/asrp_port.sv
// serial readout port: word buffer, self-clocked and external-clock shifters
`timescale 1ns/1ps
`default_nettype none
module asrp_port (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        ce_i,
    input  wire logic                        port_role_strap_i,
    input  wire logic                        cs_n_i,
    input  wire logic                        sclk_link_i,
    input  wire logic                        word_valid_i,
    input  wire logic [asrp_pkg::WORD_W-1:0] word_data_i,
    output logic                             word_ready_o,
    output logic                             rdy_n_o,
    output logic                             serial_data_output_o,
    output logic                             serial_data_output_oe_o,
    output logic                             sclk_o,
    output logic                             sclk_oe_o,
    output logic                             self_clocked_mode_o
);
    localparam int W  = asrp_pkg::WORD_W;
    localparam int LW = asrp_pkg::LCNT_W;
    localparam int CW = asrp_pkg::CNT_W;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    asrp_pkg::asrp_state_type st_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] settle_r;
    logic          mode_r;
    logic          rdy_n_r;
    logic [W-1:0]  shift_r;
    logic [W-1:0]  word_r;
    logic [LW-1:0] base_r;
    logic [LW-1:0] bit_r;
    logic          sclk_r;
    logic          held_r;
    logic          strap_s1_r;
    logic          strap_s2_r;
    logic          cs_s1_r;
    logic          cs_s2_r;
    logic [LW-1:0] lcnt_r;
    logic [LW-1:0] lgray_r;
    logic [LW-1:0] gray_s1_r;
    logic [LW-1:0] gray_s2_r;
    logic [LW-1:0] link_bin;
    logic [LW-1:0] link_diff;
    logic [LW-1:0] link_idx;
    logic          link_bit;
    logic          fifo_valid;
    logic [W-1:0]  fifo_data;
    logic          pop;
    logic          load_idle;
    logic          load_drop;

    // ------------------------------------------------------------
    // conversion word buffer
    // ------------------------------------------------------------
    asrp_fifo #(
        .WIDTH (W),
        .DEPTH (asrp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .en_i        (ce_i),
        .in_valid_i  (word_valid_i),
        .in_data_i   (word_data_i),
        .in_ready_o  (word_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (pop)
    );

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
            cs_s1_r    <= 1'b1;
            cs_s2_r    <= 1'b1;
        end else if (ce_i) begin
            strap_s1_r <= port_role_strap_i;
            strap_s2_r <= strap_s1_r;
            cs_s1_r    <= cs_n_i;
            cs_s2_r    <= cs_s1_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gray_s1_r <= '0;
            gray_s2_r <= '0;
        end else if (ce_i) begin
            gray_s1_r <= lgray_r;
            gray_s2_r <= gray_s1_r;
        end
    end

    always_comb begin
        link_bin = '0;
        for (int i = LW - 1; i >= 0; i--) begin
            if (i == LW - 1) begin
                link_bin[i] = gray_s2_r[i];
            end else begin
                link_bin[i] = link_bin[i+1] ^ gray_s2_r[i];
            end
        end
    end

    // bits the host has taken since the word was loaded
    assign link_diff = LW'(link_bin - base_r);

    // ------------------------------------------------------------
    // role strap: followed only while idle so a word never changes role
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle_r <= '0;
            mode_r   <= 1'b0;
        end else if (ce_i) begin
            if (settle_r != asrp_pkg::STRAP_SETTLE) begin
                settle_r <= CW'(settle_r + 1'b1);
            end
            if (st_r == asrp_pkg::ST_IDLE) begin
                mode_r <= strap_s2_r;
            end
        end
    end

    // ------------------------------------------------------------
    // word hand-off from the buffer
    // ------------------------------------------------------------
    assign load_idle = (st_r == asrp_pkg::ST_IDLE) && fifo_valid &&
                       (settle_r == asrp_pkg::STRAP_SETTLE);
    // unread means select held low since the load; a host that selects
    // after ready falls must not lose its word to one already buffered
    assign load_drop = (st_r == asrp_pkg::ST_WAIT) && !mode_r && !cs_s2_r && held_r &&
                       (link_diff == '0) && fifo_valid;
    assign pop       = ce_i & (load_idle | load_drop);

    // ------------------------------------------------------------
    // port sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r    <= asrp_pkg::ST_IDLE;
            cnt_r   <= '0;
            rdy_n_r <= 1'b1;
        end else if (ce_i) begin
            case (st_r)
                asrp_pkg::ST_IDLE: begin
                    if (load_idle) begin
                        st_r  <= asrp_pkg::ST_LOAD;
                        cnt_r <= CW'(asrp_pkg::MSB_LEAD_CYC - 1'b1);
                    end
                end
                asrp_pkg::ST_LOAD: begin
                    if (cnt_r == '0) begin
                        st_r    <= asrp_pkg::ST_WAIT;
                        rdy_n_r <= 1'b0;
                    end else begin
                        cnt_r <= CW'(cnt_r - 1'b1);
                    end
                end
                asrp_pkg::ST_WAIT: begin
                    if (mode_r) begin
                        if (!cs_s2_r) begin
                            st_r  <= asrp_pkg::ST_LEAD;
                            cnt_r <= CW'(asrp_pkg::SCLK_LEAD_CYC - 4'h2);
                        end
                    end else if (link_diff == asrp_pkg::WORD_BITS) begin
                        st_r    <= asrp_pkg::ST_IDLE;
                        rdy_n_r <= 1'b1;
                    end else if (load_drop) begin
                        st_r    <= asrp_pkg::ST_DROP;
                        cnt_r   <= CW'(asrp_pkg::RDY_PRE_CYC - 1'b1);
                        rdy_n_r <= 1'b1;
                    end
                end
                asrp_pkg::ST_LEAD: begin
                    if (cnt_r == '0) begin
                        st_r <= asrp_pkg::ST_SHIFT;
                    end else begin
                        cnt_r <= CW'(cnt_r - 1'b1);
                    end
                end
                asrp_pkg::ST_SHIFT: begin
                    if (!cs_s2_r && sclk_r && bit_r == asrp_pkg::WORD_BITS) begin
                        st_r  <= asrp_pkg::ST_TAIL;
                        cnt_r <= CW'(asrp_pkg::RDY_TAIL_CYC - 4'h2);
                    end
                end
                asrp_pkg::ST_TAIL: begin
                    if (cnt_r == '0) begin
                        st_r    <= asrp_pkg::ST_IDLE;
                        rdy_n_r <= 1'b1;
                    end else begin
                        cnt_r <= CW'(cnt_r - 1'b1);
                    end
                end
                asrp_pkg::ST_DROP: begin
                    if (cnt_r == '0) begin
                        st_r    <= asrp_pkg::ST_WAIT;
                        rdy_n_r <= 1'b0;
                    end else begin
                        cnt_r <= CW'(cnt_r - 1'b1);
                    end
                end
                default: begin
                    st_r    <= asrp_pkg::ST_IDLE;
                    rdy_n_r <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // self-clocked shifter: one bit per two master clocks
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_r <= '0;
            word_r  <= '0;
            base_r  <= '0;
            bit_r   <= '0;
            sclk_r  <= 1'b0;
            held_r  <= 1'b0;
        end else if (ce_i) begin
            if (cs_s2_r) begin
                held_r <= 1'b0;
            end
            if (pop) begin
                shift_r <= fifo_data;
                held_r  <= !cs_s2_r;
                word_r  <= fifo_data;
                base_r  <= link_bin;
                bit_r   <= '0;
            end
            if (st_r == asrp_pkg::ST_LEAD && cnt_r == '0) begin
                sclk_r <= 1'b1;
                bit_r  <= LW'(1);
            end
            // a deselect mid-word pauses the clock rather than losing bits
            if (st_r == asrp_pkg::ST_SHIFT && !cs_s2_r) begin
                if (sclk_r) begin
                    sclk_r <= 1'b0;
                    if (bit_r != asrp_pkg::WORD_BITS) begin
                        shift_r <= {shift_r[W-2:0], 1'b0};
                    end
                end else begin
                    sclk_r <= 1'b1;
                    bit_r  <= LW'(bit_r + 1'b1);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // external-clock side, on the host's clock
    // ------------------------------------------------------------
    // only falling edges with select low are counted; the host must
    // not clock a word before ready falls
    always_ff @(negedge sclk_link_i or posedge rst_i) begin
        if (rst_i) begin
            lcnt_r  <= '0;
            lgray_r <= '0;
        end else if (!cs_n_i && !mode_r) begin
            lcnt_r  <= LW'(lcnt_r + 1'b1);
            lgray_r <= LW'(lcnt_r + 1'b1) ^ (LW'(lcnt_r + 1'b1) >> 1);
        end
    end

    // word_r and base_r are static while a word waits, so the link side
    // reads them directly; data changes on falling edges only
    assign link_idx = LW'(lcnt_r - base_r);
    assign link_bit = (link_idx < asrp_pkg::WORD_BITS) ?
                      word_r[W-1-int'(link_idx[3:0])] : 1'b0;

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign rdy_n_o                 = rdy_n_r;
    assign self_clocked_mode_o     = mode_r;
    assign serial_data_output_o    = mode_r ? shift_r[W-1] : link_bit;
    assign serial_data_output_oe_o = !cs_s2_r;
    assign sclk_o                  = sclk_r;
    assign sclk_oe_o               = mode_r && !cs_s2_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ssc_clk_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r && st_r == asrp_pkg::ST_SHIFT && !cs_s2_r) |-> sclk_oe_o)
        else $error("self-clocked shift without clock drive");
    a_ext_no_clk: assert property (@(posedge clk_i) disable iff (rst_i)
        !mode_r |-> (!sclk_oe_o && !sclk_r))
        else $error("clock driven in external-clock mode");
    a_div_two_high: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(sclk_r) && ce_i) |=> !sclk_r)
        else $error("serial clock high longer than one master clock");
    a_ssc_hiz_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_s2_r |-> (!sclk_oe_o && !serial_data_output_oe_o))
        else $error("pins driven while deselected");
    a_ext_data_oe: assert property (@(posedge clk_i) disable iff (rst_i)
        !mode_r |-> (serial_data_output_oe_o == !cs_s2_r))
        else $error("data enable does not follow select");
    a_msb_lead: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(st_r == asrp_pkg::ST_LOAD) && ce_i) ##1 ce_i |=>
        ($fell(rdy_n_r) && shift_r[W-1] == word_r[W-1]))
        else $error("ready did not fall two cycles after msb");
    a_rdy_tail_eight: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(sclk_r) && bit_r == asrp_pkg::WORD_BITS && ce_i) ##1 ce_i[*7]
        |=> $rose(rdy_n_r))
        else $error("ready not high 8 cycles after last clock");
    a_lead_eight: assert property (@(posedge clk_i) disable iff (rst_i)
        ($fell(cs_s2_r) && mode_r && st_r == asrp_pkg::ST_WAIT && ce_i)
        ##1 (ce_i && !cs_s2_r)[*7] |=> $rose(sclk_r))
        else $error("first clock not 8 cycles after select");
    a_msb_on_select: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r && st_r == asrp_pkg::ST_WAIT && !cs_s2_r) |->
        (serial_data_output_oe_o && serial_data_output_o == word_r[W-1]))
        else $error("msb not on data pin after select");
    a_ext_rdy_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode_r && st_r == asrp_pkg::ST_WAIT && ce_i &&
         link_diff == asrp_pkg::WORD_BITS) |=> (rdy_n_r && st_r == asrp_pkg::ST_IDLE))
        else $error("ready not raised after final bit");
    a_word_ready_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r == asrp_pkg::ST_WAIT || st_r == asrp_pkg::ST_LEAD) |-> !rdy_n_r)
        else $error("word waiting with ready high");
    a_drop_pre_two: assert property (@(posedge clk_i) disable iff (rst_i)
        (load_drop && ce_i) ##1 ce_i |=> (rdy_n_r ##1 !rdy_n_r))
        else $error("ready not high two cycles before new word");
    a_word_sixteen: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r == asrp_pkg::ST_SHIFT) |-> (bit_r >= LW'(1) &&
        bit_r <= asrp_pkg::WORD_BITS))
        else $error("bit count outside word");

    c_ssc_word: cover property (@(posedge clk_i) disable iff (rst_i)
        st_r == asrp_pkg::ST_TAIL ##1 $rose(rdy_n_r));
    c_ext_word: cover property (@(posedge clk_i) disable iff (rst_i)
        !mode_r && st_r == asrp_pkg::ST_WAIT && link_diff == asrp_pkg::WORD_BITS);
    c_drop_word: cover property (@(posedge clk_i) disable iff (rst_i)
        load_drop);
    c_fifo_full: cover property (@(posedge clk_i) disable iff (rst_i)
        !word_ready_o);
endmodule // asrp_port
`default_nettype wire
